// ==== logic/dcpd_pkg.sv ====
// shared constants, types and helpers for the disk command parameter decoder
package dcpd_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int STEP_SPAN_MS = 16;
  localparam int SETTLE_UNIT_MS = 2;
  localparam int RELEASE_UNIT_MS = 16;
  localparam int SEC_BASE_BYTES = 128;
  localparam int SYNC_STAGES = 3;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SPEC = 8'h04;
  localparam logic [7:0] ADR_GEOM = 8'h08;
  localparam logic [7:0] ADR_FMT = 8'h0c;
  localparam logic [7:0] ADR_SEEK = 8'h10;
  localparam logic [7:0] ADR_GO = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;
  localparam logic [7:0] ADR_RESULT = 8'h1c;

  typedef struct packed {
    logic [1:0] scanStride;
    logic noDmaSelect;
    logic [1:0] unitSelBits;
    logic headSelectBit;
    logic deletedMarkBypass;
    logic multiSideContinue;
    logic encodingDensitySelect;
  } dcpd_ctrl_s;

  typedef struct packed {
    logic [6:0] headSettleDelay;
    logic [3:0] headReleaseDelay;
    logic [3:0] stepIntervalCode;
  } dcpd_spec_s;

  typedef struct packed {
    logic [7:0] partialSectorLength;
    logic [7:0] finalSectorNumber;
    logic [4:0] rsvd;
    logic [2:0] sectorSizeCode;
  } dcpd_geom_s;

  typedef struct packed {
    logic [7:0] startSector;
    logic [7:0] sectorsPerTrackCount;
    logic [7:0] gap3Length;
  } dcpd_fmt_s;

  localparam int CTRL_W = $bits(dcpd_ctrl_s);
  localparam int SPEC_W = $bits(dcpd_spec_s);
  localparam int GEOM_W = $bits(dcpd_geom_s);
  localparam int FMT_W = $bits(dcpd_fmt_s);
  localparam dcpd_ctrl_s CTRL_RST = '0;
  localparam dcpd_spec_s SPEC_RST = '0;
  localparam dcpd_geom_s GEOM_RST = '0;
  localparam dcpd_fmt_s FMT_RST = '0;
  localparam logic [7:0] TARGET_RST = 8'h00;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_FORMAT = 3'h2,
    OP_SCAN = 3'h3,
    OP_SEEK = 3'h4,
    OP_SENSE = 3'h5
  } dcpd_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_XFER = 3'b011,
    ST_GAP = 3'b010,
    ST_RESULT = 3'b110,
    ST_STEP = 3'b100
  } dcpd_state_e;

  // inverted code: f gives 1 ms, 0 gives 16 ms
  function automatic logic [7:0] step_ms(input logic [3:0] code);
    return 8'(STEP_SPAN_MS - int'(code));
  endfunction : step_ms

  function automatic logic [7:0] settle_ms(input logic [6:0] code);
    return (code == 7'h00) ? 8'(SETTLE_UNIT_MS) : 8'(int'(code) * SETTLE_UNIT_MS);
  endfunction : settle_ms

  function automatic logic [7:0] release_ms(input logic [3:0] code);
    return (code == 4'h0) ? 8'(RELEASE_UNIT_MS) : 8'(int'(code) * RELEASE_UNIT_MS);
  endfunction : release_ms

  // size code 0 takes the partial length instead
  function automatic logic [15:0] sec_len(input logic [2:0] size, input logic [7:0] part);
    if (size == 3'h0) begin
      return (part == 8'h00) ? 16'h0001 : {8'h00, part};
    end
    return 16'(SEC_BASE_BYTES << size);
  endfunction : sec_len
endpackage : dcpd_pkg

// ==== logic/dcpd_ms_timer.sv ====
// millisecond tick and one-shot delay of a programmed number of ms
`timescale 1ns/1ps
module dcpd_ms_timer
  import dcpd_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [7:0] loadMs,
  output logic busy,
  output logic done
);
  localparam int PW = $clog2(TICK_CYC + 1);
  logic [PW-1:0] preCnt_ff;
  logic [7:0] msCnt_ff;
  logic done_ff;
  wire tick = preCnt_ff == PW'(TICK_CYC - 1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      preCnt_ff <= '0;
      msCnt_ff <= 8'h00;
      done_ff <= 1'b0;
    end else if (clkEn) begin
      done_ff <= 1'b0;
      if (load) begin
        preCnt_ff <= '0;
        msCnt_ff <= (loadMs == 8'h00) ? 8'h01 : loadMs;
      end else if (msCnt_ff != 8'h00) begin
        preCnt_ff <= tick ? '0 : preCnt_ff + PW'(1);
        if (tick) begin
          msCnt_ff <= msCnt_ff - 8'h01;
          done_ff <= msCnt_ff == 8'h01;
        end
      end
    end
  end

  assign busy = msCnt_ff != 8'h00;
  assign done = done_ff;
endmodule : dcpd_ms_timer

// ==== logic/dcpd_core.sv ====
// command parameter decoder and sector sequencer of the diskette controller
`timescale 1ns/1ps
module dcpd_core
  import dcpd_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic byteStrobePin,
  input wire logic [7:0] diskDataPin,
  input wire logic deletedMarkPin,
  input wire logic [7:0] hostScanData,
  output logic headSel,
  output logic [1:0] unitSel,
  output logic mfmMode,
  output logic headLoad,
  output logic stepPulse,
  output logic stepDirIn,
  output logic vcoHoldLow,
  output logic gapWrite,
  output logic dmaReq,
  output logic pioReq
);
  dcpd_ctrl_s cfg_ff;
  dcpd_spec_s spec_ff;
  dcpd_geom_s geom_ff;
  dcpd_fmt_s fmt_ff;
  logic [7:0] target_ff;
  dcpd_state_e state_ff, nxt_state;
  dcpd_op_e op_ff, nxt_op;
  logic [7:0] cyl_ff, nxt_cyl, sector_ff, nxt_sector, secDone_ff, nxt_secDone;
  logic [7:0] gapCnt_ff, nxt_gapCnt;
  logic [15:0] byteCnt_ff, nxt_byteCnt;
  logic side_ff, nxt_side, skip_ff, nxt_skip, mismatch_ff, nxt_mismatch;
  logic delSeen_ff, nxt_delSeen, seekEnd_ff, nxt_seekEnd;
  logic headLoad_ff, nxt_headLoad, stepPulse_ff, nxt_stepPulse, stepDir_ff, nxt_stepDir;
  logic [31:0] rdata_ff;
  logic [SYNC_STAGES-1:0] strobeSync_ff;
  logic [7:0] dataMeta_ff, dataSync_ff;
  logic [1:0] delSync_ff;
  logic seqLoad, relLoad, seqBusy, seqDone, relDone;
  logic [7:0] seqMs;

  // pin inputs: two flops, a third only for the strobe edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strobeSync_ff <= '0;
      dataMeta_ff <= 8'h00;
      dataSync_ff <= 8'h00;
      delSync_ff <= 2'h0;
    end else if (clkEn) begin
      strobeSync_ff <= {strobeSync_ff[SYNC_STAGES-2:0], byteStrobePin};
      dataMeta_ff <= diskDataPin;
      dataSync_ff <= dataMeta_ff;
      delSync_ff <= {delSync_ff[0], deletedMarkPin};
    end
  end

  wire byteEdge = strobeSync_ff[1] && !strobeSync_ff[2];
  wire busy = state_ff != ST_IDLE;
  wire isFormat = op_ff == OP_FORMAT;
  wire isScan = op_ff == OP_SCAN;
  wire isReadLike = (op_ff == OP_READ) || isScan;
  wire [15:0] secLen = sec_len(geom_ff.sectorSizeCode, geom_ff.partialSectorLength);
  wire newSkip = cfg_ff.deletedMarkBypass && isReadLike && delSync_ff[1];
  wire curSkip = (byteCnt_ff == 16'h0000) ? newSkip : skip_ff;
  wire lastByte = byteEdge && (byteCnt_ff == secLen - 16'h0001);
  wire [7:0] gapLen = fmt_ff.gap3Length;
  wire gapDone = (state_ff == ST_GAP)
      && ((gapLen == 8'h00) || (byteEdge && (gapCnt_ff == gapLen - 8'h01)));
  wire lastSector = isFormat ? (secDone_ff + 8'h01 == fmt_ff.sectorsPerTrackCount)
                             : (sector_ff == geom_ff.finalSectorNumber);
  wire [7:0] strideInc = (isScan && cfg_ff.scanStride == 2'h2) ? 8'h02 : 8'h01;
  wire byteReq = (state_ff == ST_XFER) && byteEdge && !curSkip;
  wire headIdle = (state_ff == ST_IDLE) || (state_ff == ST_RESULT) || (state_ff == ST_STEP);

  // register port decode
  wire wrCtrl = regWr && (regAddr == ADR_CTRL) && !busy;
  wire wrSpec = regWr && (regAddr == ADR_SPEC);
  wire wrGeom = regWr && (regAddr == ADR_GEOM) && !busy;
  wire wrFmt = regWr && (regAddr == ADR_FMT) && !busy;
  wire wrSeek = regWr && (regAddr == ADR_SEEK) && !busy;
  wire goWr = regWr && (regAddr == ADR_GO) && !busy && (regWdata[2:0] <= OP_SENSE);
  wire resultRd = regRd && (regAddr == ADR_RESULT) && (state_ff == ST_RESULT);
  wire [7:0] st0 = {2'h0, seekEnd_ff, 2'h0, side_ff, cfg_ff.unitSelBits};
  wire [7:0] st1 = (op_ff == OP_SENSE) ? cyl_ff : sector_ff;
  wire [7:0] st2 = {1'b0, delSeen_ff, 2'h0, isScan && !mismatch_ff, mismatch_ff, 2'h0};
  wire [31:0] resultWord = {cyl_ff, st2, st1, st0};
  wire [31:0] statWord = {7'h00, side_ff, sector_ff, cyl_ff, 5'h00, headLoad_ff,
                          state_ff == ST_RESULT, busy};
  wire [31:0] rdMux =
      (regAddr == ADR_CTRL) ? 32'(cfg_ff) :
      (regAddr == ADR_SPEC) ? 32'(spec_ff) :
      (regAddr == ADR_GEOM) ? 32'(geom_ff) :
      (regAddr == ADR_FMT) ? 32'(fmt_ff) :
      (regAddr == ADR_SEEK) ? {24'h000000, target_ff} :
      (regAddr == ADR_STAT) ? statWord :
      (state_ff == ST_RESULT && regAddr == ADR_RESULT) ? resultWord : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_ff <= CTRL_RST;
      spec_ff <= SPEC_RST;
      geom_ff <= GEOM_RST;
      fmt_ff <= FMT_RST;
      target_ff <= TARGET_RST;
      rdata_ff <= 32'h00000000;
    end else if (clkEn) begin
      if (wrCtrl) cfg_ff <= dcpd_ctrl_s'(regWdata[CTRL_W-1:0]);
      if (wrSpec) spec_ff <= dcpd_spec_s'(regWdata[SPEC_W-1:0]);
      if (wrGeom) geom_ff <= dcpd_geom_s'(regWdata[GEOM_W-1:0]);
      if (wrFmt) fmt_ff <= dcpd_fmt_s'(regWdata[FMT_W-1:0]);
      if (wrSeek) target_ff <= regWdata[7:0];
      rdata_ff <= regRd ? rdMux : 32'h00000000;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_cyl = cyl_ff;
    nxt_sector = sector_ff;
    nxt_secDone = secDone_ff;
    nxt_gapCnt = gapCnt_ff;
    nxt_byteCnt = byteCnt_ff;
    nxt_side = side_ff;
    nxt_skip = skip_ff;
    nxt_mismatch = mismatch_ff;
    nxt_delSeen = delSeen_ff;
    nxt_seekEnd = seekEnd_ff;
    nxt_headLoad = headLoad_ff;
    nxt_stepPulse = 1'b0;
    nxt_stepDir = stepDir_ff;
    seqLoad = 1'b0;
    seqMs = 8'h00;
    relLoad = 1'b0;
    // release may expire while the host lingers in the result phase or seeks
    if (relDone && headIdle) nxt_headLoad = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_side = cfg_ff.headSelectBit;
        if (goWr) begin
          nxt_op = dcpd_op_e'(regWdata[2:0]);
          nxt_seekEnd = 1'b0;
          nxt_mismatch = 1'b0;
          nxt_delSeen = 1'b0;
          nxt_sector = fmt_ff.startSector;
          nxt_secDone = 8'h00;
          nxt_byteCnt = 16'h0000;
          nxt_gapCnt = 8'h00;
          case (dcpd_op_e'(regWdata[2:0]))
            OP_SEEK: begin
              nxt_state = ST_STEP;
              seqLoad = 1'b1;
              seqMs = step_ms(spec_ff.stepIntervalCode);
            end
            OP_SENSE: nxt_state = ST_RESULT;
            default: begin
              nxt_headLoad = 1'b1;
              if (headLoad_ff && !relDone) begin
                nxt_state = ST_XFER;
              end else begin
                nxt_state = ST_SETTLE;
                seqLoad = 1'b1;
                seqMs = settle_ms(spec_ff.headSettleDelay);
              end
            end
          endcase
        end
      end
      ST_SETTLE: if (seqDone) nxt_state = ST_XFER;
      ST_XFER: begin
        if (byteEdge) begin
          nxt_byteCnt = byteCnt_ff + 16'h0001;
          nxt_skip = curSkip;
          if (curSkip) nxt_delSeen = 1'b1;
          if (isScan && !curSkip && dataSync_ff != hostScanData) nxt_mismatch = 1'b1;
        end
        if (lastByte) begin
          nxt_byteCnt = 16'h0000;
          nxt_gapCnt = 8'h00;
          nxt_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (byteEdge) nxt_gapCnt = gapCnt_ff + 8'h01;
        if (gapDone) begin
          nxt_secDone = secDone_ff + 8'h01;
          if (!lastSector) begin
            nxt_sector = sector_ff + strideInc;
            nxt_state = ST_XFER;
          end else if (cfg_ff.multiSideContinue && !side_ff && !isFormat) begin
            nxt_side = 1'b1;
            nxt_sector = 8'h01;
            nxt_state = ST_XFER;
          end else begin
            nxt_state = ST_RESULT;
            relLoad = 1'b1;
          end
        end
      end
      ST_STEP: begin
        if (cyl_ff == target_ff) begin
          nxt_seekEnd = 1'b1;
          nxt_state = ST_RESULT;
        end else if (seqDone) begin
          nxt_stepPulse = 1'b1;
          nxt_stepDir = target_ff > cyl_ff;
          nxt_cyl = (target_ff > cyl_ff) ? cyl_ff + 8'h01 : cyl_ff - 8'h01;
          seqLoad = 1'b1;
          seqMs = step_ms(spec_ff.stepIntervalCode);
        end
      end
      ST_RESULT: if (resultRd) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_READ;
      {cyl_ff, sector_ff, secDone_ff, gapCnt_ff} <= 32'h00000000;
      byteCnt_ff <= 16'h0000;
      {side_ff, skip_ff, mismatch_ff, delSeen_ff} <= 4'h0;
      {seekEnd_ff, headLoad_ff, stepPulse_ff, stepDir_ff} <= 4'h0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      {cyl_ff, sector_ff, secDone_ff, gapCnt_ff} <= {nxt_cyl, nxt_sector, nxt_secDone, nxt_gapCnt};
      byteCnt_ff <= nxt_byteCnt;
      {side_ff, skip_ff, mismatch_ff, delSeen_ff} <= {nxt_side, nxt_skip, nxt_mismatch, nxt_delSeen};
      {seekEnd_ff, headLoad_ff, stepPulse_ff, stepDir_ff} <=
          {nxt_seekEnd, nxt_headLoad, nxt_stepPulse, nxt_stepDir};
    end
  end

  dcpd_ms_timer #(.TICK_CYC(TICK_CYC)) seqTimer (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .load(seqLoad), .loadMs(seqMs), .busy(seqBusy), .done(seqDone)
  );

  dcpd_ms_timer #(.TICK_CYC(TICK_CYC)) relTimer (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .load(relLoad), .loadMs(release_ms(spec_ff.headReleaseDelay)), .busy(), .done(relDone)
  );

  assign regRdata = rdata_ff;
  assign headSel = side_ff;
  assign unitSel = cfg_ff.unitSelBits;
  assign mfmMode = cfg_ff.encodingDensitySelect;
  assign headLoad = headLoad_ff;
  assign stepPulse = stepPulse_ff;
  assign stepDirIn = stepDir_ff;
  assign vcoHoldLow = (state_ff == ST_GAP) && !isFormat;
  assign gapWrite = (state_ff == ST_GAP) && isFormat;
  assign dmaReq = byteReq && !cfg_ff.noDmaSelect;
  assign pioReq = byteReq && cfg_ff.noDmaSelect;

  default clocking dcpdClk @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  vco_after_crc_a: assert property (clkEn && state_ff == ST_XFER && lastByte && !isFormat
      |=> vcoHoldLow) else $error("vco not held low after sector");
  format_gap_a: assert property (clkEn && state_ff == ST_XFER && lastByte && isFormat
      |=> gapWrite && !vcoHoldLow) else $error("format gap not written");
  head_follow_a: assert property (clkEn && state_ff == ST_IDLE && !goWr
      |=> headSel == $past(cfg_ff.headSelectBit)) else $error("head select mismatch");
  settle_entry_a: assert property (clkEn && goWr && regWdata[2:0] < OP_SEEK && !headLoad_ff
      |=> state_ff == ST_SETTLE && headLoad && seqBusy) else $error("no settle after load");
  head_unload_a: assert property (clkEn && state_ff == ST_IDLE && relDone && !goWr
      |=> !headLoad) else $error("head not unloaded");
  density_set_a: assert property (clkEn && wrCtrl
      |=> mfmMode == $past(regWdata[0])) else $error("density not applied");
  side_continue_a: assert property (clkEn && gapDone && lastSector && !isFormat
      && cfg_ff.multiSideContinue && !side_ff |=> side_ff && sector_ff == 8'h01
      && state_ff == ST_XFER) else $error("no side 1 continuation");
  step_move_a: assert property (stepPulse |-> cyl_ff != $past(cyl_ff))
      else $error("step without cylinder change");
  scan_stride_a: assert property (clkEn && gapDone && !lastSector && isScan
      && cfg_ff.scanStride == 2'h2 |=> sector_ff == $past(sector_ff) + 8'h02)
      else $error("scan stride 2 not applied");
  result_hide_a: assert property (clkEn && regRd && regAddr == ADR_RESULT
      && state_ff != ST_RESULT |=> regRdata == 32'h00000000) else $error("result leaked");
  skip_noreq_a: assert property (state_ff == ST_XFER && byteEdge && curSkip
      |-> !dmaReq && !pioReq) else $error("request on skipped sector");
  seek_end_a: assert property (clkEn && state_ff == ST_STEP && cyl_ff == target_ff
      |=> state_ff == ST_RESULT && seekEnd_ff) else $error("seek did not end");
  final_stop_a: assert property (clkEn && gapDone && lastSector && !isFormat
      && !cfg_ff.multiSideContinue |=> state_ff == ST_RESULT) else $error("no stop at final");
endmodule : dcpd_core

// ==== bench/dcpd_disk_model.sv ====
// drive side model: byte strobes, disk bytes and deleted mark while spinning
`timescale 1ns/1ps
module dcpd_disk_model #(
  parameter int BYTE_CYC = 8
) (
  input wire logic core_clk,
  input wire logic spin,
  input wire logic deletedIn,
  output logic byteStrobePin,
  output logic [7:0] diskDataPin,
  output logic deletedMarkPin
);
  int phase = 0;
  logic [7:0] lastByte = 8'h5a;
  initial begin
    byteStrobePin = 1'b0;
    diskDataPin = 8'ha5;
    deletedMarkPin = 1'b0;
  end
  // strobe changes off the controller edge, as an unrelated drive would
  always @(negedge core_clk) begin
    if (spin) begin
      phase = (phase + 1) % BYTE_CYC;
      byteStrobePin <= (phase < 2);
      if (phase == 0) begin
        lastByte = lastByte + 8'h01;
      end
      diskDataPin <= lastByte;
      deletedMarkPin <= deletedIn;
    end else begin
      // released bus shows the inverse of the last byte, not a stale copy
      byteStrobePin <= 1'b0;
      diskDataPin <= ~lastByte;
      deletedMarkPin <= 1'b0;
      phase = 0;
    end
  end
endmodule : dcpd_disk_model

// ==== bench/dcpd_core_tb.sv ====
// self-checking bench of the command parameter decoder
`timescale 1ns/1ps
module dcpd_core_tb;
  import dcpd_pkg::*;
  localparam int TCYC = 4;
  logic core_clk, sys_rst, regWr, regRd, spin, deletedIn;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rdv;
  logic byteStrobePin, deletedMarkPin, headSel, mfmMode, headLoad, stepPulse, stepDirIn;
  logic vcoHoldLow, gapWrite, dmaReq, pioReq, clkEn;
  logic [7:0] diskDataPin;
  logic [1:0] unitSel;
  int fail_count = 0, check_count = 0, cyc = 0, dmaCnt, pioCnt, stepCnt, stepGap, lastStep;
  bit vcoSeen, gapSeen;

  dcpd_core #(.TICK_CYC(TCYC)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .byteStrobePin(byteStrobePin), .diskDataPin(diskDataPin),
    .deletedMarkPin(deletedMarkPin), .hostScanData(8'h00), .headSel(headSel),
    .unitSel(unitSel), .mfmMode(mfmMode), .headLoad(headLoad), .stepPulse(stepPulse),
    .stepDirIn(stepDirIn), .vcoHoldLow(vcoHoldLow), .gapWrite(gapWrite), .dmaReq(dmaReq),
    .pioReq(pioReq));
  dcpd_disk_model DRV (.core_clk(core_clk), .spin(spin), .deletedIn(deletedIn),
    .byteStrobePin(byteStrobePin), .diskDataPin(diskDataPin),
    .deletedMarkPin(deletedMarkPin));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (dmaReq === 1'b1) dmaCnt <= dmaCnt + 1;
    if (pioReq === 1'b1) pioCnt <= pioCnt + 1;
    if (vcoHoldLow === 1'b1) vcoSeen <= 1'b1;
    if (gapWrite === 1'b1) gapSeen <= 1'b1;
    if (stepPulse === 1'b1) begin
      stepCnt <= stepCnt + 1;
      stepGap <= cyc - lastStep;
      lastStep <= cyc;
    end
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask : rd

  // polls the result phase flag, then returns the result word
  task automatic wait_result();
    int n;
    n = 0;
    rd(ADR_STAT);
    while (rdv[1] !== 1'b1 && n < 3000) begin
      rd(ADR_STAT);
      n++;
    end
    chk({31'h0, rdv[1]}, 32'h1);
    rd(ADR_RESULT);
  endtask : wait_result

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  logic [2:0] tOp [6] = '{3'h0, 3'h1, 3'h3, 3'h0, 3'h0, 3'h2};
  logic [31:0] tCtrl [6] = '{32'h1, 32'h40, 32'h100, 32'h2, 32'h4, 32'h0};
  logic [7:0] tFinal [6] = '{8'h02, 8'h02, 8'h03, 8'h01, 8'h02, 8'h03};
  int tExp [6] = '{6, 6, 6, 6, 0, 9};

  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    spin = 1'b0;
    deletedIn = 1'b0;
    dmaCnt = 0;
    pioCnt = 0;
    stepCnt = 0;
    lastStep = 0;
    stepGap = 0;
    vcoSeen = 1'b0;
    gapSeen = 1'b0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    // reset state and quiet reads
    rd(ADR_STAT);
    chk(rdv, 32'h0);
    rd(ADR_RESULT);
    chk(rdv, 32'h0);
    rd(8'h40);
    chk(rdv, 32'h0);
    $display("test reset done");
    // command bits reach the drive pins
    wr(ADR_CTRL, 32'h19);
    @(posedge core_clk);
    #1 chk({28'h0, unitSel, headSel, mfmMode}, 32'h7);
    wr(ADR_CTRL, 32'h0);
    @(posedge core_clk);
    #1 chk({28'h0, unitSel, headSel, mfmMode}, 32'h0);
    // a write while the clock enable is low must not land
    clkEn <= 1'b0;
    wr(ADR_CTRL, 32'h19);
    clkEn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk({28'h0, unitSel, headSel, mfmMode}, 32'h0);
    $display("test ctrl done");
    // seek two cylinders with the fastest step code
    wr(ADR_SPEC, 32'h0000011f);
    wr(ADR_SEEK, 32'h2);
    wr(ADR_GO, 32'h4);
    wait_result();
    chk({31'h0, rdv[5]}, 32'h1);
    chk({24'h0, rdv[31:24]}, 32'h2);
    chk(stepCnt, 32'h2);
    chk({31'h0, (stepGap >= TCYC && stepGap <= 2 * TCYC)}, 32'h1);
    chk({31'h0, stepDirIn}, 32'h1);
    wr(ADR_GO, 32'h5);
    wait_result();
    chk({24'h0, rdv[15:8]}, 32'h2);
    $display("test seek done");
    // data commands: partial length 3 bytes per sector, sectors from 1
    wr(ADR_FMT, 32'h00010302);
    spin = 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(ADR_CTRL, tCtrl[i]);
      wr(ADR_GEOM, {8'h00, 8'h03, tFinal[i], 8'h00});
      deletedIn = (i == 4);
      dmaCnt = 0;
      pioCnt = 0;
      wr(ADR_GO, {29'h0, tOp[i]});
      wait_result();
      chk({31'h0, headLoad}, 32'h1);
      chk(dmaCnt + pioCnt, tExp[i]);
      chk(tCtrl[i][6] ? dmaCnt : pioCnt, 32'h0);
      chk({24'h0, rdv[15:8]}, {24'h0, tFinal[i]});
      chk({31'h0, rdv[22]}, {31'h0, i == 4});
      chk({30'h0, rdv[19:18]}, {30'h0, 1'b0, tOp[i] == 3'h3});
      chk({31'h0, rdv[2]}, {31'h0, i == 3});
      $display("test data op %0d done", i);
    end
    chk({31'h0, vcoSeen}, 32'h1);
    chk({31'h0, gapSeen}, 32'h1);
    spin = 1'b0;
    // release code 1 is 16 ms, 64 cycles at the reduced tick
    repeat (16 * TCYC + 16) @(posedge core_clk);
    chk({31'h0, headLoad}, 32'h0);
    $display("test release done");
    print_verdict();
  end
endmodule : dcpd_core_tb
